// ---- src/fwp_pkg.sv ----
// constants and types for the flash power and write-protect block
package fwp_pkg;

  // instruction codes
  localparam logic [7:0] FWP_OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] FWP_OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] FWP_OP_STATUS_WRITE      = 8'h01;
  localparam logic [7:0] FWP_OP_PAGE_PROGRAM      = 8'h02;
  localparam logic [7:0] FWP_OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] FWP_OP_SECTOR_ERASE      = 8'h20;
  localparam logic [7:0] FWP_OP_HALF_BLOCK_ERASE  = 8'h52;
  localparam logic [7:0] FWP_OP_BLOCK_ERASE       = 8'hD8;
  localparam logic [7:0] FWP_OP_CHIP_ERASE        = 8'hC7;
  localparam logic [7:0] FWP_OP_ENTER_SLEEP       = 8'hB9;
  localparam logic [7:0] FWP_OP_WAKE              = 8'hAB;
  localparam logic [7:0] FWP_OP_RESET_ARM         = 8'h66;
  localparam logic [7:0] FWP_OP_RESET             = 8'h99;

  // status_protection_register field positions
  localparam int FWP_SR_BUSY_BIT   = 0;
  localparam int FWP_SR_LATCH_BIT  = 1;
  localparam int FWP_SR_CODE_LSB   = 2;
  localparam int FWP_SR_CODE_MSB   = 5;
  localparam int FWP_SR_DIR_BIT    = 3;
  localparam int FWP_SR_UNIT_BIT   = 4;
  localparam int FWP_SR_BOOT_BIT   = 6;
  localparam int FWP_SR_PERM_BIT   = 7;

  // reset values
  localparam logic [3:0] FWP_CODE_RST = 4'h0;
  localparam logic       FWP_BIT_RST  = 1'b0;

  // frame length limits, in whole bytes (counter saturates at 7)
  localparam logic [2:0] FWP_BYTES_CMD_ONLY   = 3'h1;
  localparam logic [2:0] FWP_BYTES_STATUS_MIN = 3'h2;
  localparam logic [2:0] FWP_BYTES_ADDR_EXACT = 3'h4;
  localparam logic [2:0] FWP_BYTES_PROG_MIN   = 3'h5;
  localparam logic [2:0] FWP_BYTES_SAT        = 3'h7;
  localparam logic [2:0] FWP_BIT_LAST         = 3'h7;

  // array geometry on the 24-bit address
  localparam int FWP_ADDR_MSB   = 22;
  localparam int FWP_BLOCK_LSB  = 16;
  localparam int FWP_SECTOR_LSB = 12;

  // power-up write inhibit time
  localparam int FWP_MCLK_PERIOD_NS = 25;
  localparam int FWP_PUW_TIME_US    = 10;
  localparam int FWP_PUW_CYCLES_I   =
    (FWP_PUW_TIME_US * 1000 + FWP_MCLK_PERIOD_NS - 1) / FWP_MCLK_PERIOD_NS;
  localparam logic [9:0] FWP_PUW_CYCLES = 10'(FWP_PUW_CYCLES_I);

  typedef enum logic [2:0] {
    FWP_PWR_ACTIVE  = 3'b001,
    FWP_PWR_STANDBY = 3'b010,
    FWP_PWR_SLEEP   = 3'b100
  } fwp_power_t;

endpackage

// ---- src/fwp_link_capture.sv ----
// serial-clock side: shifts in one frame and holds its bytes and bit count
`timescale 1ns/1ps
module fwp_link_capture (
  input  wire logic        sclk,
  input  wire logic        reset_n,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic [7:0]       frame_opcode,
  output logic [23:0]      frame_addr,
  output logic [7:0]       frame_data,
  output logic [2:0]       frame_bytes,
  output logic [2:0]       frame_bit_phase,
  output logic             frame_tag
);

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data;
    logic [6:0]  shift;
    logic [2:0]  bits;
    logic [2:0]  bytes;
    logic        tag;
  } fwp_link_t;

  fwp_link_t   s;
  fwp_link_t   next_s;
  logic        started;
  logic [2:0]  bits_base;
  logic [2:0]  bytes_base;
  logic [7:0]  byte_in;

  // the serial clock stops between frames, so the frame start is marked by
  // chip select itself; the counts survive the frame for the other domain
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  always_comb begin
    next_s     = s;
    bits_base  = started ? s.bits : 3'h0;
    bytes_base = started ? s.bytes : 3'h0;
    byte_in    = {s.shift, mosi};
    next_s.shift = byte_in[6:0];
    next_s.bits  = bits_base + 3'h1;
    next_s.bytes = bytes_base;
    if (!started) begin
      next_s.tag = ~s.tag;
    end
    if (bits_base == fwp_pkg::FWP_BIT_LAST) begin
      unique case (bytes_base)
        3'h0: next_s.opcode = byte_in;
        3'h1: begin
          next_s.data         = byte_in;
          next_s.addr[23:16]  = byte_in;
        end
        3'h2: next_s.addr[15:8] = byte_in;
        3'h3: next_s.addr[7:0]  = byte_in;
        default: ;
      endcase
      if (bytes_base != fwp_pkg::FWP_BYTES_SAT) begin
        next_s.bytes = bytes_base + 3'h1;
      end
    end
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign frame_opcode    = s.opcode;
  assign frame_addr      = s.addr;
  assign frame_data      = s.data;
  assign frame_bytes     = s.bytes;
  assign frame_bit_phase = s.bits;
  assign frame_tag       = s.tag;

endmodule

// ---- src/fwp_flash_protect.sv ----
// power modes, write-enable latch and array protection of a serial flash
// Operation
// - select low keeps device active
// - stay active until internal cycle ends
// - sleep instruction enters deep sleep until wake
// - deep sleep ignores all but wake
// - power-up timer blocks modifying operations
// - modify frames need whole-byte clock count
// - modify only while write latch set
// - latch clears on completions and reset
// - protect code marks region read-only
// - permanent bit freezes protect code forever; a hardware reset clears it here
// - top mapping of protect codes
// - bottom mapping mirrors top mapping
// - boot-lock bit locks end block/sector
// - boot-lock direction and unit selection
// - direction and unit programmable once
// - busy flag shows running internal cycle
// - reset needs arm instruction just before
`timescale 1ns/1ps
module fwp_flash_protect (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               mosi,
  input  wire logic               op_busy,
  output logic                    op_start,
  output logic [7:0]              op_code,
  output logic [23:0]             op_addr,
  output logic [7:0]              status_protection_register,
  output fwp_pkg::fwp_power_t     power_state
);

  typedef struct packed {
    logic                 cs_meta;
    logic                 cs_sync;
    logic                 cs_prev;
    logic                 tag_seen;
    fwp_pkg::fwp_power_t  power;
    logic [9:0]           puw_count;
    logic                 puw_done;
    logic                 write_enable_latch;
    logic [3:0]           protect_code;
    logic                 boot_lock_enable_bit;
    logic                 permanent_lock_bit;
    logic                 boot_lock_direction_bit;
    logic                 boot_unit_sector;
    logic                 boot_cfg_fixed;
    logic                 reset_armed;
    logic                 launched;
    logic                 seen_busy;
    logic                 start;
    logic [7:0]           code;
    logic [23:0]          addr;
  } fwp_state_t;

  fwp_state_t   s;
  fwp_state_t   next_s;

  logic [7:0]   frame_opcode;
  logic [23:0]  frame_addr;
  logic [7:0]   frame_data;
  logic [2:0]   frame_bytes;
  logic [2:0]   frame_bit_phase;
  logic         frame_tag;

  fwp_link_capture u_link (
    .sclk            (sclk),
    .reset_n         (reset_n),
    .cs_n            (cs_n),
    .mosi            (mosi),
    .frame_opcode    (frame_opcode),
    .frame_addr      (frame_addr),
    .frame_data      (frame_data),
    .frame_bytes     (frame_bytes),
    .frame_bit_phase (frame_bit_phase),
    .frame_tag       (frame_tag)
  );

  // lowest protected (mirrored) block index for a protect code; 128 = none
  function automatic logic [7:0] fwp_code_floor(input logic [3:0] code);
    logic [7:0] floor_blk;
    floor_blk = 8'h80;
    unique case (code)
      4'h0: floor_blk = 8'h80;
      4'h1: floor_blk = 8'h7F;
      4'h2: floor_blk = 8'h7E;
      4'h3: floor_blk = 8'h7C;
      4'h4: floor_blk = 8'h78;
      4'h5: floor_blk = 8'h70;
      4'h6: floor_blk = 8'h60;
      4'h7: floor_blk = 8'h40;
      4'h8: floor_blk = 8'h20;
      4'h9: floor_blk = 8'h10;
      4'hA: floor_blk = 8'h08;
      4'hB: floor_blk = 8'h04;
      4'hC: floor_blk = 8'h02;
      4'hD: floor_blk = 8'h01;
      4'hE: floor_blk = 8'h00;
      4'hF: floor_blk = 8'h00;
    endcase
    return floor_blk;
  endfunction

  // bottom protection is the top table seen through an inverted address
  function automatic logic fwp_is_protected(
    input logic [3:0]  code,
    input logic        bottom,
    input logic        boot_en,
    input logic        unit_sector,
    input logic        whole_chip,
    input logic [23:0] addr
  );
    logic [6:0]  blk;
    logic [10:0] sec;
    logic        hit;
    blk = addr[fwp_pkg::FWP_ADDR_MSB:fwp_pkg::FWP_BLOCK_LSB];
    sec = addr[fwp_pkg::FWP_ADDR_MSB:fwp_pkg::FWP_SECTOR_LSB];
    if (bottom) begin
      blk = ~blk;
      sec = ~sec;
    end
    hit = ({1'b0, blk} >= fwp_code_floor(code));
    if (boot_en) begin
      hit = hit | (unit_sector ? (&sec) : (&blk));
    end
    if (whole_chip) begin
      hit = (code != fwp_pkg::FWP_CODE_RST) | boot_en;
    end
    return hit;
  endfunction

  logic         cs_rise;
  logic         frame_go;
  logic         whole_bytes;
  logic         is_program;
  logic         is_addr_erase;
  logic         is_chip_erase;
  logic         is_status_write;
  logic         len_ok;
  logic         target_hit;
  logic         may_modify;
  logic         cycle_done;

  always_comb begin
    next_s = s;
    // chip select crosses on two flops; frame words are quiet once it is high
    next_s.cs_meta = cs_n;
    next_s.cs_sync = s.cs_meta;
    next_s.cs_prev = s.cs_sync;
    next_s.start   = 1'b0;

    cs_rise         = s.cs_sync & ~s.cs_prev;
    frame_go        = cs_rise & (frame_tag != s.tag_seen);
    whole_bytes     = (frame_bit_phase == 3'h0);
    is_program      = (frame_opcode == fwp_pkg::FWP_OP_PAGE_PROGRAM) |
                      (frame_opcode == fwp_pkg::FWP_OP_QUAD_PAGE_PROGRAM);
    is_addr_erase   = (frame_opcode == fwp_pkg::FWP_OP_SECTOR_ERASE) |
                      (frame_opcode == fwp_pkg::FWP_OP_HALF_BLOCK_ERASE) |
                      (frame_opcode == fwp_pkg::FWP_OP_BLOCK_ERASE);
    is_chip_erase   = (frame_opcode == fwp_pkg::FWP_OP_CHIP_ERASE);
    is_status_write = (frame_opcode == fwp_pkg::FWP_OP_STATUS_WRITE);
    len_ok = (is_program & (frame_bytes >= fwp_pkg::FWP_BYTES_PROG_MIN)) |
             (is_addr_erase & (frame_bytes == fwp_pkg::FWP_BYTES_ADDR_EXACT)) |
             (is_chip_erase & (frame_bytes == fwp_pkg::FWP_BYTES_CMD_ONLY)) |
             (is_status_write & (frame_bytes >= fwp_pkg::FWP_BYTES_STATUS_MIN));
    target_hit = fwp_is_protected(s.protect_code, s.boot_lock_direction_bit,
                                  s.boot_lock_enable_bit, s.boot_unit_sector,
                                  is_chip_erase, frame_addr);
    may_modify = whole_bytes &
                 s.write_enable_latch &
                 s.puw_done &
                 ~s.launched &
                 len_ok;
    cycle_done = s.launched & s.seen_busy & ~op_busy;

    if (frame_go) begin
      next_s.tag_seen = frame_tag;
    end

    // power-up write inhibit
    if (!s.puw_done) begin
      next_s.puw_count = s.puw_count + 10'h001;
      if (s.puw_count == fwp_pkg::FWP_PUW_CYCLES - 10'h001) begin
        next_s.puw_done = 1'b1;
      end
    end

    // internal cycle tracking; the clear is applied before any frame so a
    // set arriving in the same cycle wins
    if (s.launched && op_busy) begin
      next_s.seen_busy = 1'b1;
    end
    if (cycle_done) begin
      next_s.launched           = 1'b0;
      next_s.seen_busy          = 1'b0;
      next_s.write_enable_latch = 1'b0;
    end

    if (frame_go && s.power == fwp_pkg::FWP_PWR_SLEEP) begin
      if (frame_opcode == fwp_pkg::FWP_OP_WAKE && frame_bytes != 3'h0) begin
        next_s.power = fwp_pkg::FWP_PWR_STANDBY;
      end
    end else if (frame_go && frame_bytes != 3'h0) begin
      next_s.reset_armed = (frame_opcode == fwp_pkg::FWP_OP_RESET_ARM) &
                           whole_bytes;
      unique case (frame_opcode)
        fwp_pkg::FWP_OP_RESET: begin
          if (s.reset_armed && !s.launched) begin
            next_s.write_enable_latch = 1'b0;
          end
        end
        fwp_pkg::FWP_OP_SET_WRITE_LATCH: begin
          if (whole_bytes) begin
            next_s.write_enable_latch = 1'b1;
          end
        end
        fwp_pkg::FWP_OP_CLEAR_WRITE_LATCH: begin
          if (whole_bytes) begin
            next_s.write_enable_latch = 1'b0;
          end
        end
        fwp_pkg::FWP_OP_ENTER_SLEEP: begin
          if (whole_bytes && !s.launched) begin
            next_s.power = fwp_pkg::FWP_PWR_SLEEP;
          end
        end
        fwp_pkg::FWP_OP_STATUS_WRITE: begin
          if (may_modify) begin
            if (!s.permanent_lock_bit) begin
              next_s.protect_code =
                frame_data[fwp_pkg::FWP_SR_CODE_MSB:fwp_pkg::FWP_SR_CODE_LSB];
              next_s.permanent_lock_bit = frame_data[fwp_pkg::FWP_SR_PERM_BIT];
            end
            next_s.boot_lock_enable_bit = frame_data[fwp_pkg::FWP_SR_BOOT_BIT];
            if (!s.boot_cfg_fixed) begin
              next_s.boot_lock_direction_bit = frame_data[fwp_pkg::FWP_SR_DIR_BIT];
              next_s.boot_unit_sector        = frame_data[fwp_pkg::FWP_SR_UNIT_BIT];
              next_s.boot_cfg_fixed          = 1'b1;
            end
            // a status write completes at once, so the latch drops here
            next_s.write_enable_latch = 1'b0;
          end
        end
        default: begin
          if ((is_program || is_addr_erase || is_chip_erase) &&
              may_modify && !target_hit) begin
            next_s.start    = 1'b1;
            next_s.launched = 1'b1;
            next_s.code     = frame_opcode;
            next_s.addr     = frame_addr;
          end
        end
      endcase
    end

    // power state follows select and the internal cycle outside deep sleep
    if (s.power != fwp_pkg::FWP_PWR_SLEEP && next_s.power != fwp_pkg::FWP_PWR_SLEEP) begin
      if (!s.cs_sync) begin
        next_s.power = fwp_pkg::FWP_PWR_ACTIVE;
      end else if (next_s.launched) begin
        next_s.power = fwp_pkg::FWP_PWR_ACTIVE;
      end else begin
        next_s.power = fwp_pkg::FWP_PWR_STANDBY;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s                         <= '0;
      s.cs_meta                 <= 1'b1;
      s.cs_sync                 <= 1'b1;
      s.cs_prev                 <= 1'b1;
      s.power                   <= fwp_pkg::FWP_PWR_STANDBY;
      s.protect_code            <= fwp_pkg::FWP_CODE_RST;
      s.write_enable_latch      <= fwp_pkg::FWP_BIT_RST;
      s.boot_lock_enable_bit    <= fwp_pkg::FWP_BIT_RST;
      s.boot_lock_direction_bit <= fwp_pkg::FWP_BIT_RST;
      s.boot_unit_sector        <= fwp_pkg::FWP_BIT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign op_start    = s.start;
  assign op_code     = s.code;
  assign op_addr     = s.addr;
  assign power_state = s.power;

  always_comb begin
    status_protection_register = 8'h00;
    status_protection_register[fwp_pkg::FWP_SR_BUSY_BIT]  = s.launched;
    status_protection_register[fwp_pkg::FWP_SR_LATCH_BIT] = s.write_enable_latch;
    status_protection_register[fwp_pkg::FWP_SR_CODE_MSB:fwp_pkg::FWP_SR_CODE_LSB] =
      s.protect_code;
    status_protection_register[fwp_pkg::FWP_SR_BOOT_BIT]  = s.boot_lock_enable_bit;
    status_protection_register[fwp_pkg::FWP_SR_PERM_BIT]  = s.permanent_lock_bit;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_engine_done;
    op_busy ##1 !op_busy;
  endsequence

  sequence s_sleep_frame;
    frame_go && s.power == fwp_pkg::FWP_PWR_SLEEP;
  endsequence

  a_select_active: assert property (
    (!s.cs_sync && s.power != fwp_pkg::FWP_PWR_SLEEP) |=> power_state == fwp_pkg::FWP_PWR_ACTIVE)
    else $error("device not active while selected");

  a_standby_idle: assert property (
    s.launched && s.power != fwp_pkg::FWP_PWR_SLEEP |-> power_state == fwp_pkg::FWP_PWR_ACTIVE)
    else $error("standby entered during internal cycle");

  a_sleep_holds: assert property (
    (s.power == fwp_pkg::FWP_PWR_SLEEP && !(frame_go && frame_opcode == fwp_pkg::FWP_OP_WAKE))
      |=> power_state == fwp_pkg::FWP_PWR_SLEEP)
    else $error("deep sleep left without wake");

  a_sleep_ignores: assert property (
    s_sleep_frame |=> !op_start && $stable(s.write_enable_latch) && $stable(s.protect_code))
    else $error("instruction acted on in deep sleep");

  a_powerup_block: assert property (
    !s.puw_done |=> !op_start && $stable(s.protect_code))
    else $error("modify allowed before power-up timer");

  a_whole_bytes: assert property (
    (frame_go && frame_bit_phase != 3'h0) |=> !op_start && $stable(s.protect_code))
    else $error("partial byte frame accepted");

  a_latch_needed: assert property (
    op_start |-> $past(s.write_enable_latch))
    else $error("array start without write latch");

  a_latch_clears: assert property (
    (s.launched && s.seen_busy) ##0 s_engine_done ##0 !frame_go |=> !s.launched && !s.write_enable_latch)
    else $error("write latch kept after cycle end");

  a_perm_frozen: assert property (
    s.permanent_lock_bit |=> s.permanent_lock_bit && $stable(s.protect_code))
    else $error("protect code changed under permanent lock");

  a_boot_once: assert property (
    s.boot_cfg_fixed |=> $stable(s.boot_lock_direction_bit) && $stable(s.boot_unit_sector))
    else $error("boot-lock selection changed twice");

  a_busy_flag: assert property (
    op_start |-> status_protection_register[0] [*2])
    else $error("busy flag missing after start");

  a_reset_paired: assert property (
    (frame_go && s.power != fwp_pkg::FWP_PWR_SLEEP && frame_opcode == fwp_pkg::FWP_OP_RESET
      && !s.reset_armed && !cycle_done && s.write_enable_latch) |=> s.write_enable_latch)
    else $error("reset taken without arm");

  a_protected_skip: assert property (
    (frame_go && target_hit) |=> !op_start)
    else $error("protected target sent to array");

endmodule

// ---- dv/fwp_spi_host.sv ----
// host model of the serial link: frames sent msb first, clock idles low
`timescale 1ns/1ps
module fwp_spi_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic frame(input logic [47:0] d, input int nbits);
    #3 cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = d[47-i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    // released line shows the inverse so a stale bit never reads as data
    mosi = ~mosi;
  endtask
  // quiet gap of 150 ns lets the system clock see each frame apart
  task automatic modify(input logic [47:0] d, input int nbits);
    frame({fwp_pkg::FWP_OP_SET_WRITE_LATCH, 40'h0}, 8);
    #150;
    frame(d, nbits);
  endtask
  task automatic soft_reset();
    frame({fwp_pkg::FWP_OP_RESET_ARM, 40'h0}, 8);
    #150;
    frame({fwp_pkg::FWP_OP_RESET, 40'h0}, 8);
  endtask
endmodule

// ---- dv/fwp_flash_protect_test.sv ----
// self-checking bench for the flash power and write-protect block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module fwp_flash_protect_test;
  logic                mclk;
  logic                reset_n = 1'b0;
  logic                sclk;
  logic                cs_n;
  logic                mosi;
  logic                op_busy = 1'b0;
  logic                op_start;
  logic [7:0]          op_code;
  logic [23:0]         op_addr;
  logic [7:0]          sr;
  fwp_pkg::fwp_power_t power_state;
  logic [3:0]          busy_cnt = 4'h0;
  logic [31:0]         want;
  logic [31:0]         exp_q[$];
  logic [7:0]          exp_sr = 8'h00;
  logic [7:0]          ops[5] = '{8'h02, 8'h32, 8'h20, 8'h52, 8'hD8};
  int                  lens[5] = '{40, 40, 32, 32, 32};
  integer              seed = 32'h7E97;
  int                  n_fail = 0;
  int                  n_tests = 0;

  fwp_spi_host i_fwp_spi_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  fwp_flash_protect i_fwp_flash_protect (
    .mclk                       (mclk),
    .reset_n                    (reset_n),
    .sclk                       (sclk),
    .cs_n                       (cs_n),
    .mosi                       (mosi),
    .op_busy                    (op_busy),
    .op_start                   (op_start),
    .op_code                    (op_code),
    .op_addr                    (op_addr),
    .status_protection_register (sr),
    .power_state                (power_state)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // array engine stand-in with a random busy length
  always @(posedge mclk) begin
    if (op_start === 1'b1)
      busy_cnt <= 4'h2 + 4'($unsigned($random(seed)) % 6);
    else if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
    op_busy <= (op_start === 1'b1) || (busy_cnt > 4'h1);
  end

  always @(posedge mclk) begin
    if (op_start === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[ERR] %0t unexpected array operation %h", $time, op_code);
      end else begin
        want = exp_q.pop_front();
        `CHK({op_code, op_addr}, want)
      end
      `CHK(sr[0], 1'b1)
      `CHK(power_state, fwp_pkg::FWP_PWR_ACTIVE)
    end
  end

  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask

  task automatic send(input logic [47:0] d, input int nbits);
    i_fwp_spi_host.frame(d, nbits);
    settle();
  endtask

  // ok says whether the array engine should see the request
  task automatic modify(input logic [7:0] op, input logic [23:0] a, input int nbits, input bit ok);
    int i;
    i = 0;
    if (ok)
      exp_q.push_back({op, a});
    i_fwp_spi_host.modify({op, a, 8'h5A, 8'h00}, nbits);
    while (ok && op_busy !== 1'b1 && i < 20) begin
      @(posedge mclk);
      i++;
    end
    while (ok && op_busy !== 1'b0 && i < 40) begin
      @(posedge mclk);
      i++;
    end
    settle();
    if (ok) begin
      `CHK(i < 20, 1'b1)
      `CHK(power_state, fwp_pkg::FWP_PWR_STANDBY)
    end
    `CHK(sr, ok ? exp_sr : (exp_sr | 8'h02))
  endtask

  task automatic wr_status(input logic [7:0] d, input logic [7:0] e);
    i_fwp_spi_host.modify({fwp_pkg::FWP_OP_STATUS_WRITE, d, 32'h0}, 16);
    settle();
    exp_sr = e;
    `CHK(sr, exp_sr)
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    `CHK(sr, 8'h00)
    `CHK(power_state, fwp_pkg::FWP_PWR_STANDBY)
    send({8'h06, 40'h0}, 8);
    `CHK(sr, 8'h02)
    send({8'h01, 8'h3C, 32'h0}, 16);
    `CHK(sr, 8'h02)
    $display("test power-up inhibit done");
    repeat (fwp_pkg::FWP_PUW_CYCLES) @(posedge mclk);
    send({8'h01, 8'h3C, 32'h0}, 15);
    `CHK(sr, 8'h02)
    send({8'h02, 24'h001000, 8'h5A, 8'h00}, 39);
    `CHK(sr, 8'h02)
    modify(8'h20, 24'h001000, 40, 1'b0);
    $display("test partial frames done");
    wr_status(8'h40, 8'h40);
    modify(8'h02, 24'h7F0000, 40, 1'b0);
    modify(8'h02, 24'h7E0000, 40, 1'b1);
    modify(8'hC7, 24'h000000, 8, 1'b0);
    $display("test boot lock done");
    // direction bit is fixed by the first write, so code 0110 stays on top
    wr_status(8'h18, 8'h18);
    modify(8'h20, 24'h600000, 32, 1'b0);
    modify(8'h20, 24'h5FF000, 32, 1'b1);
    for (int k = 0; k < 5; k++)
      modify(ops[k], 24'h001000, lens[k], 1'b1);
    modify(8'hC7, 24'h000000, 8, 1'b0);
    $display("test protect map done");
    fork
      i_fwp_spi_host.frame({8'h06, 40'h0}, 48);
      begin
        #400;
        `CHK(power_state, fwp_pkg::FWP_PWR_ACTIVE)
      end
    join
    settle();
    send({8'h04, 40'h0}, 8);
    `CHK(sr, 8'h18)
    send({8'hB9, 40'h0}, 8);
    `CHK(power_state, fwp_pkg::FWP_PWR_SLEEP)
    send({8'h06, 40'h0}, 8);
    send({8'h20, 24'h001000, 8'h00, 8'h00}, 32);
    `CHK(sr, 8'h18)
    `CHK(power_state, fwp_pkg::FWP_PWR_SLEEP)
    send({8'hAB, 40'h0}, 32);
    `CHK(power_state, fwp_pkg::FWP_PWR_STANDBY)
    $display("test deep sleep done");
    wr_status(8'h88, 8'h88);
    wr_status(8'h7C, 8'hC8);
    send({8'h06, 40'h0}, 8);
    i_fwp_spi_host.soft_reset();
    settle();
    `CHK(sr, 8'hC8)
    send({8'h06, 40'h0}, 8);
    send({8'h66, 40'h0}, 8);
    send({8'h06, 40'h0}, 8);
    send({8'h99, 40'h0}, 8);
    `CHK(sr, 8'hCA)
    $display("test lock and reset done");
    // only a reset frees the once-only selection, so bottom cases come last
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    `CHK(sr, 8'h00)
    `CHK(power_state, fwp_pkg::FWP_PWR_STANDBY)
    repeat (fwp_pkg::FWP_PUW_CYCLES) @(posedge mclk);
    wr_status(8'h5C, 8'h5C);
    modify(8'h20, 24'h3F0000, 32, 1'b0);
    modify(8'h20, 24'h400000, 32, 1'b1);
    wr_status(8'h40, 8'h40);
    modify(8'h20, 24'h000000, 32, 1'b0);
    modify(8'h20, 24'h001000, 32, 1'b1);
    `CHK(exp_q.size() == 0, 1'b1)
    $display("test bottom lock done");
    end_of_test();
  end
endmodule
